/* rtl/rsq_pkg.sv */
// Constants, types and register map for the processor system reset sequencer
// Functional notes
// [R01] External request must persist minimum width first
// [R02] Auxiliary input: own width, same behaviour
// [R03] Asynchronous inputs pass a metastability synchroniser
// [R04] Width five: outputs assert six/seven clocks later
// [R05] Release begins after request inactive full width
// [R06] Request during release reasserts every output
// [R07] External polarity setting selects active level
// [R08] Auxiliary polarity setting selects active level
// [R09] Replicated bus and interconnect reset outputs
// [R10] Interconnect resets are active low
// [R11] Peripheral resets in high and low vectors
// [R12] Debugger reset: external width, always active high
// [R13] System ties lock high or drives it
// [R14] Integrator clocks block from slowest clock
// [R15] All outputs assert on one clock edge
// [R16] Release: bus, peripherals +16, core +16
// [R17] Power-up: assert early, hold sixteen clocks
// [R18] Shared minimum width one to sixteen, default four
// [R19] One to eight bus copies, each flopped
// [R20] Processor core reset is active high
// [R21] Lock low holds reset; release after lock
// [R22] Two-stage synchroniser ahead of width counter
package rsq_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    ST_POR,   // Power-on hold, everything asserted
    ST_HOLD,  // Held by a live request
    ST_BUS,   // Bus and interconnect released
    ST_PERP,  // Peripherals released as well
    ST_RUN    // Everything released
  } rsq_state_t;

  // Timing, counts in clocks of the slowest clock
  localparam int RSQ_SEQ_GAP      = 16;  // Release step spacing
  localparam int RSQ_POR_HOLD     = 16;  // Power-on hold length
  localparam int RSQ_CNT_W        = 5;   // Counter width, holds up to 31
  localparam logic [4:0] RSQ_GAP_LAST = 5'(RSQ_SEQ_GAP - 1);
  localparam logic [4:0] RSQ_POR_LAST = 5'(RSQ_POR_HOLD - 1);

  // Parameter defaults
  localparam int RSQ_EXT_WIDTH_DEF = 4;  // Shared external and debugger width
  localparam int RSQ_AUX_WIDTH_DEF = 4;  // Auxiliary width
  localparam bit RSQ_EXT_HIGH_DEF  = 1'b1;
  localparam bit RSQ_AUX_HIGH_DEF  = 1'b1;
  localparam int RSQ_COPIES_DEF    = 1;

  // Register map, byte addresses on the APB
  localparam logic [11:0] RSQ_CTRL_OFS = 12'h000;  // Control, write
  localparam logic [11:0] RSQ_STAT_OFS = 12'h004;  // Status, read only
  localparam int          RSQ_CTRL_SOFT_BIT = 0;   // Write 1: pulse a reset
  localparam logic [31:0] RSQ_CTRL_RST = 32'h0000_0000;
  // Status fields
  localparam int RSQ_ST_CORE = 0;
  localparam int RSQ_ST_PERP = 1;
  localparam int RSQ_ST_BUS  = 2;
  localparam int RSQ_ST_LOCK = 3;
  localparam int RSQ_ST_EXT  = 4;
  localparam int RSQ_ST_AUX  = 5;

endpackage

/* rtl/rsq_sequencer.sv */
// Reset input filters, release sequencer and APB status slave
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns

// Width filter: output flips only after WIDTH agreeing samples
module rsq_width_filter
  import rsq_pkg::*;
#(
  parameter int WIDTH = RSQ_EXT_WIDTH_DEF
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic smp,
  output logic      hit
);

  localparam logic [4:0] LAST = 5'(WIDTH - 1);

  logic       state_reg;  // Filtered level
  logic       state_next;
  logic [4:0] cnt_reg;    // Run length of disagreeing samples
  logic [4:0] cnt_next;

  // Any break in the run restarts the count
  always_comb begin
    state_next = state_reg;
    cnt_next   = 5'h00;
    if (smp != state_reg) begin
      if (cnt_reg == LAST) begin
        state_next = smp;  // [R01] [R05]
      end else begin
        cnt_next = 5'(cnt_reg + 5'h01);  // [R22]
      end
    end
  end

  // Next filtered level goes out at once to save a clock of latency
  assign hit = state_next;  // [R04]

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= 1'b0;
      cnt_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_filter_rise: assert property (  // [R01]
    $rose(state_reg) |-> $past(cnt_reg) == LAST && $past(smp))
    else $error("filter rose before full width");
  chk_filter_fall: assert property (  // [R05]
    $fell(state_reg) |-> $past(cnt_reg) == LAST && !$past(smp))
    else $error("filter fell before full width");

endmodule

// Top: synchronisers, filters, sequencer, replicated outputs, APB slave
module rsq_sequencer
  import rsq_pkg::*;
#(
  parameter int EXT_WIDTH               = RSQ_EXT_WIDTH_DEF,  // 1..16
  parameter int AUX_WIDTH               = RSQ_AUX_WIDTH_DEF,  // 1..16
  parameter bit EXT_HIGH                = RSQ_EXT_HIGH_DEF,
  parameter bit AUX_HIGH                = RSQ_AUX_HIGH_DEF,
  parameter int BUS_COPIES              = RSQ_COPIES_DEF,     // 1..8
  parameter int IC_COPIES               = RSQ_COPIES_DEF,     // 1..8
  parameter int DEVICE_RESET_COPIES     = RSQ_COPIES_DEF,     // 1..16
  parameter int DEVICE_LOW_RESET_COPIES = RSQ_COPIES_DEF      // 1..16
) (
  input  wire logic                               core_clk,
  input  wire logic                               rstn,
  input  wire logic                               ext_reset_in,
  input  wire logic                               aux_reset_in,
  input  wire logic                               debugger_system_reset,
  input  wire logic                               clock_lock,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  output logic                                    processor_core_reset,
  output logic      [BUS_COPIES-1:0]              bus_struct_reset,
  output logic      [IC_COPIES-1:0]               interconnect_reset_n,
  output logic      [DEVICE_RESET_COPIES-1:0]     peripheral_reset,
  output logic      [DEVICE_LOW_RESET_COPIES-1:0] peripheral_reset_n
);

  // Inputs turned to active-high before the first stage; gate, not tap
  logic [3:0] raw_act;
  logic [3:0] sync1_reg;  // First stage, read only by the second
  logic [3:0] sync2_reg;  // Settled levels

  assign raw_act = {clock_lock,
                    debugger_system_reset,              // [R12]
                    aux_reset_in ~^ AUX_HIGH,           // [R08]
                    ext_reset_in ~^ EXT_HIGH};          // [R07]

  // Two-stage synchroniser; adds one or two clocks by input phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= raw_act;    // [R03] [R22]
      sync2_reg <= sync1_reg;  // [R03]
    end
  end

  logic ext_smp;  // External or debugger, sharing one width
  logic ext_hit;  // Qualified external request
  logic aux_hit;  // Qualified auxiliary request
  logic lock_ok;  // Clock manager locked

  assign ext_smp = sync2_reg[0] | sync2_reg[2];  // [R12]
  assign lock_ok = sync2_reg[3];

  // External and debugger filter
  rsq_width_filter #(.WIDTH(EXT_WIDTH)) u_ext_filter (  // [R18]
    .core_clk (core_clk),
    .rstn     (rstn),
    .smp      (ext_smp),
    .hit      (ext_hit)
  );

  // Auxiliary filter, same structure, own width
  rsq_width_filter #(.WIDTH(AUX_WIDTH)) u_aux_filter (  // [R02]
    .core_clk (core_clk),
    .rstn     (rstn),
    .smp      (sync2_reg[1]),
    .hit      (aux_hit)
  );

  // Sequencer state
  rsq_state_t state_reg;
  rsq_state_t state_next;
  logic [4:0] cnt_reg;   // Clocks spent in the current phase
  logic [4:0] cnt_next;
  logic       soft_reg;  // One-cycle software reset pulse
  logic       soft_next;
  logic       req_any;   // Any live reset cause

  // Lock low counts as a request, so release waits for lock
  assign req_any = ext_hit | aux_hit | ~lock_ok | soft_reg;  // [R21]

  // Phase advance; a request outside power-on drops back to hold
  always_comb begin
    state_next = state_reg;
    cnt_next   = 5'(cnt_reg + 5'h01);
    unique case (state_reg)
      ST_POR: begin
        // Requests already covered, power-on runs its full length
        if (cnt_reg == RSQ_POR_LAST) begin  // [R17]
          state_next = req_any ? ST_HOLD : ST_BUS;
          cnt_next   = 5'h00;
        end
      end
      ST_HOLD: begin
        cnt_next = 5'h00;
        if (!req_any) begin
          state_next = ST_BUS;  // [R05]
        end
      end
      ST_BUS: begin
        if (cnt_reg == RSQ_GAP_LAST) begin  // [R16]
          state_next = ST_PERP;
          cnt_next   = 5'h00;
        end
      end
      ST_PERP: begin
        if (cnt_reg == RSQ_GAP_LAST) begin  // [R16]
          state_next = ST_RUN;
          cnt_next   = 5'h00;
        end
      end
      ST_RUN: begin
        cnt_next = 5'h00;
      end
    endcase
    if (req_any && state_reg != ST_POR) begin
      state_next = ST_HOLD;  // [R06]
      cnt_next   = 5'h00;
    end
  end

  // Output levels follow the next phase, so all assert on one edge
  logic bus_on;
  logic perp_on;
  logic core_on;

  always_comb begin
    bus_on  = (state_next == ST_POR) || (state_next == ST_HOLD);  // [R15]
    perp_on = bus_on || (state_next == ST_BUS);
    core_on = (state_next != ST_RUN);
  end

  logic [BUS_COPIES-1:0]              bus_reg;    // One flop per copy
  logic [IC_COPIES-1:0]               ic_n_reg;
  logic [DEVICE_RESET_COPIES-1:0]     perp_reg;
  logic [DEVICE_LOW_RESET_COPIES-1:0] perp_n_reg;
  logic                               core_reg;

  // Sequencer and replicated output registers; reset means all asserted
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_reg  <= ST_POR;                           // [R17]
      cnt_reg    <= 5'h00;
      bus_reg    <= '1;
      ic_n_reg   <= '0;
      perp_reg   <= '1;
      perp_n_reg <= '0;
      core_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      bus_reg    <= {BUS_COPIES{bus_on}};             // [R09] [R19]
      ic_n_reg   <= {IC_COPIES{~bus_on}};             // [R10]
      perp_reg   <= {DEVICE_RESET_COPIES{perp_on}};   // [R11]
      perp_n_reg <= {DEVICE_LOW_RESET_COPIES{~perp_on}};
      core_reg   <= core_on;                          // [R20]
    end
  end

  assign bus_struct_reset     = bus_reg;
  assign interconnect_reset_n = ic_n_reg;
  assign peripheral_reset     = perp_reg;
  assign peripheral_reset_n   = perp_n_reg;
  assign processor_core_reset = core_reg;

  // APB slave: one wait state, registered answer
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pready_next;
  logic        pslverr_reg;
  logic        pslverr_next;
  logic        first_acc;  // First access cycle, answer prepared
  logic        done;       // Completing edge
  logic        hit_ctrl;
  logic        hit_stat;

  assign first_acc = psel & penable & ~pready_reg;
  assign done      = psel & penable & pready_reg;
  assign hit_ctrl  = (paddr == RSQ_CTRL_OFS);
  assign hit_stat  = (paddr == RSQ_STAT_OFS);

  // Decode; status writes are ignored, unmapped gets an error
  always_comb begin
    pready_next  = first_acc;
    pslverr_next = first_acc & ~hit_ctrl & ~hit_stat;
    prdata_next  = 32'h0000_0000;
    soft_next    = 1'b0;
    if (first_acc && !pwrite && hit_stat) begin
      prdata_next[RSQ_ST_CORE] = core_reg;
      prdata_next[RSQ_ST_PERP] = perp_reg[0];
      prdata_next[RSQ_ST_BUS]  = bus_reg[0];
      prdata_next[RSQ_ST_LOCK] = lock_ok;
      prdata_next[RSQ_ST_EXT]  = ext_hit;
      prdata_next[RSQ_ST_AUX]  = aux_hit;
    end
    // Pulse rather than level: a held bit would keep the core in reset
    if (done && pwrite && hit_ctrl) begin
      soft_next = pwdata[RSQ_CTRL_SOFT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata_reg  <= RSQ_CTRL_RST;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      soft_reg    <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      soft_reg    <= soft_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Checking helpers: clocks since reset release, saturating
  logic [4:0] por_age_reg;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      por_age_reg <= 5'h00;
    end else if (por_age_reg != 5'h1f) begin
      por_age_reg <= 5'(por_age_reg + 5'h01);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_same_edge: assert property (  // [R15]
    bus_reg[0] |-> core_reg && perp_reg[0] && !ic_n_reg[0] && !perp_n_reg[0])
    else $error("outputs not asserted together");
  chk_perp_gap: assert property (  // [R16]
    $fell(perp_reg[0]) |-> !$past(bus_reg[0], 16) && $past(bus_reg[0], 17))
    else $error("peripheral release not 16 after bus");
  chk_core_gap: assert property (  // [R16]
    $fell(core_reg) |-> !$past(perp_reg[0], 16) && $past(perp_reg[0], 17))
    else $error("core release not 16 after peripherals");
  chk_req_reassert: assert property (req_any |=> bus_reg[0] && core_reg && perp_reg[0]) // [R06]
    else $error("request did not reassert outputs");
  chk_lock_holds: assert property (  // [R21]
    !lock_ok |=> bus_reg[0] && (state_reg == ST_POR || state_reg == ST_HOLD))
    else $error("released while unlocked");
  chk_ic_polarity: assert property (  // [R10]
    ic_n_reg == {IC_COPIES{!bus_reg[0]}}
    && perp_n_reg == {DEVICE_LOW_RESET_COPIES{!perp_reg[0]}})
    else $error("active-low copies disagree");
  chk_por_hold: assert property ((por_age_reg < 5'h10) |-> bus_reg[0] && core_reg) // [R17]
    else $error("power-on hold too short");
  chk_ext_latency: assert property (  // [R04]
    $rose(ext_hit) && state_reg == ST_RUN |=> bus_reg[0] && core_reg)
    else $error("external request not seen next edge");

endmodule

/* verification/rsq_partner.sv */
// Far-side model: clock manager lock and reset consumers
`timescale 1ns/1ns
module rsq_partner (
  input  wire logic       core_clk,
  input  wire logic       lock_want,
  input  wire logic       bus_rst,
  input  wire logic       perp_rst,
  input  wire logic       core_rst,
  output logic            clock_lock,
  output logic [7:0]      gap_perp,
  output logic [7:0]      gap_core
);
  logic [7:0] age_reg;  // Clocks since the bus came out of reset

  // Lock from the manager that locks last; bench holds it high otherwise
  assign clock_lock = lock_want;

  // Consumers stamp their own release against the bus release.
  // Same slow clock as the sequencer, so no crossing here
  always @(posedge core_clk) begin
    if (bus_rst) begin
      age_reg  <= 8'h00;
      gap_perp <= 8'h00;
      gap_core <= 8'h00;
    end else begin
      age_reg <= age_reg + 8'h01;
      // Still held: its release edge is the next stamp
      if (perp_rst) gap_perp <= age_reg + 8'h01;
      if (core_rst) gap_core <= age_reg + 8'h01;
    end
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module tb;
  import rsq_pkg::*;
  localparam int WE = 5;  // External and debugger width
  localparam int WA = 3;  // Auxiliary width
  typedef struct { int src; int dly; } rsq_row_t;
  // Source 0 external, 1 debugger, 2 auxiliary; edges to reach ports
  rsq_row_t rows[3] = '{'{0, WE + 2}, '{1, WE + 2}, '{2, WA + 2}};
  logic        core_clk, rstn, ext_reset_in, aux_reset_in;
  logic        debugger_system_reset, clock_lock, lock_want;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        processor_core_reset;
  logic [1:0]  bus_struct_reset, interconnect_reset_n, peripheral_reset_n;
  logic [2:0]  peripheral_reset;
  logic [7:0]  gap_perp, gap_core;
  int          n_fail, compares, n;

  // External active high (default), auxiliary active low, copies above one
  rsq_sequencer #(.EXT_WIDTH(WE), .AUX_WIDTH(WA), .AUX_HIGH(1'b0),
    .BUS_COPIES(2), .IC_COPIES(2), .DEVICE_RESET_COPIES(3), .DEVICE_LOW_RESET_COPIES(2))
  u_rsq_sequencer (.core_clk, .rstn, .ext_reset_in, .aux_reset_in, .debugger_system_reset,
    .clock_lock, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .processor_core_reset, .bus_struct_reset, .interconnect_reset_n, .peripheral_reset,
    .peripheral_reset_n);

  rsq_partner u_rsq_partner (.core_clk, .lock_want, .bus_rst(bus_struct_reset[0]),
    .perp_rst(peripheral_reset[0]), .core_rst(processor_core_reset), .clock_lock,
    .gap_perp, .gap_core);

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  // Every copy of every group at reset level v, each in its polarity
  function automatic bit all_at(input logic v);
    return bus_struct_reset === {2{v}} && interconnect_reset_n === {2{~v}}
      && peripheral_reset === {3{v}} && peripheral_reset_n === {2{~v}}
      && processor_core_reset === v;
  endfunction

  // Raise or drop one request source at a rising edge
  task automatic req(input int src, input logic on);
    @(posedge core_clk);
    case (src)
      0: ext_reset_in <= on;
      1: debugger_system_reset <= on;
      default: aux_reset_in <= ~on;
    endcase
  endtask

  // Edges until bus (or core) reset reaches v; bounded
  task automatic edges_until(input bit core, input logic v, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while ((core ? processor_core_reset : bus_struct_reset[0]) !== v && k < 200);
    if (k >= 200) begin
      check(1'b0, "wait timed out");
      summarize();
    end
  endtask

  // APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      check(1'b0, "apb timed out");
      summarize();
    end
  endtask

  // Full release order, stamped by the far side
  task automatic full_release(input string msg);
    edges_until(1'b1, 1'b0, n);
    check(gap_perp === 8'h10 && gap_core === 8'h20 && all_at(1'b0), msg);
  endtask

  initial begin
    rstn = 1'b0;
    ext_reset_in = 1'b0;
    aux_reset_in = 1'b1;
    debugger_system_reset = 1'b0;
    lock_want = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_fail = 0;
    compares = 0;
    // Reset low for five edges
    repeat (4) @(posedge core_clk);
    #1;
    check(all_at(1'b1), "reset level");
    @(posedge core_clk);
    rstn <= 1'b1;
    edges_until(1'b0, 1'b0, n);
    check(n == 16, "power-up hold");
    full_release("power-up order");
    $display("test power-up done");
    // Each source: assert latency, width filter, release order
    foreach (rows[i]) begin
      req(rows[i].src, 1'b1);
      edges_until(1'b0, 1'b1, n);
      check(n == rows[i].dly && all_at(1'b1), "assert delay");
      req(rows[i].src, 1'b0);
      edges_until(1'b0, 1'b0, n);
      check(n == rows[i].dly, "release delay");
      full_release("release order");
      $display("test row %0d done", i);
    end
    // Pulse one clock short of the width leaves no trace
    req(0, 1'b1);
    repeat (WE - 2) @(posedge core_clk);
    req(0, 1'b0);
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (bus_struct_reset !== 2'b00) n++;
    end
    check(n == 0, "short pulse");
    $display("test short pulse done");
    // New request while peripherals are still held
    req(0, 1'b1);
    edges_until(1'b0, 1'b1, n);
    req(0, 1'b0);
    edges_until(1'b0, 1'b0, n);
    req(0, 1'b1);
    edges_until(1'b0, 1'b1, n);
    check(n == WE + 2 && all_at(1'b1), "reassert");
    req(0, 1'b0);
    full_release("reassert order");
    $display("test reassert done");
    // Lock loss holds everything until lock returns
    @(posedge core_clk);
    lock_want <= 1'b0;
    edges_until(1'b0, 1'b1, n);
    check(n == 3 && all_at(1'b1), "lock low");
    repeat (30) @(posedge core_clk);
    #1;
    check(all_at(1'b1), "lock hold");
    @(posedge core_clk);
    lock_want <= 1'b1;
    edges_until(1'b0, 1'b0, n);
    check(n == 3, "lock release");
    full_release("lock order");
    $display("test lock done");
    // Registers: read-only status, unmapped place, soft reset
    apb(1'b1, RSQ_STAT_OFS, 32'hFFFF_FFFF);
    apb(1'b0, RSQ_STAT_OFS, 32'h0000_0000);
    check(rd === 32'h0000_0008 && er === 1'b0, "status");
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(er === 1'b1, "unmapped");
    apb(1'b1, RSQ_CTRL_OFS, 32'h0000_0001);
    edges_until(1'b0, 1'b1, n);
    check(n == 1 && all_at(1'b1), "soft reset");
    full_release("soft order");
    $display("test registers done");
    // Mid-run reset: all asserted at once, power-on hold runs again
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(all_at(1'b1), "mid-run reset level");
    @(posedge core_clk);
    rstn <= 1'b1;
    edges_until(1'b0, 1'b0, n);
    check(n == 16, "mid-run power-up hold");
    full_release("mid-run order");
    $display("test mid-run reset done");
    summarize();
  end
endmodule
